/* src/mnsx_pkg.sv */
// Package with opcodes, phases, flag positions and reset values for the execution unit.
package mnsx_pkg;
  // Opcode prefixes of the 16-bit instruction word.
  localparam logic [7:0] OP_MUL_LIT   = 8'h0D;    // 0000 1101 kkkk kkkk
  localparam logic [6:0] OP_MUL_FILE  = 7'h01;    // 0000 001a ffff ffff
  localparam logic [6:0] OP_NEG_FILE  = 7'h36;    // 0110 110a ffff ffff
  localparam logic [5:0] OP_SUB_FILE  = 6'h17;    // 0101 11da ffff ffff
  localparam logic [7:0] OP_SUB_LIT   = 8'h08;    // 0000 1000 kkkk kkkk
  localparam logic [3:0] OP_IDLE_WIDE = 4'hF;     // 1111 xxxx xxxx xxxx
  // Field positions in the instruction word.
  localparam int DEST_BIT   = 9;
  localparam int ACCESS_BIT = 8;
  // Flag positions in the flag vector.
  localparam int FLG_C  = 0;
  localparam int FLG_DC = 1;
  localparam int FLG_Z  = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_N  = 4;
  // Access bank split: offsets below this go to bank 0, the rest to bank 15.
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  // Reset values.
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [4:0] RST_FLAGS = 5'h00;
  localparam logic [3:0] RST_BANK  = 4'h0;
  // Operation selected in decode.
  typedef enum logic [2:0] {OPK_IDLE, OPK_MUL_LIT, OPK_MUL_FILE, OPK_NEG, OPK_SUB_FILE,
                            OPK_SUB_LIT} mnsx_op_t;
  // Four phases of one instruction cycle.
  typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} mnsx_phase_t;
endpackage : mnsx_pkg

/* src/mnsx_exec_unit.sv */
// Execution unit for multiply, negate, subtract and idle instructions in four phases.
`timescale 1ns/1ps
`default_nettype none
module mnsx_exec_unit (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic [15:0] instr_i,            // Instruction word, sampled in decode.
  input  wire logic [7:0]  mem_rdata_i,        // Data memory read data, valid the cycle after read.
  input  wire logic [3:0]  bank_wr_data_i,     // New bank select value.
  input  wire logic        bank_wr_i,          // Load the bank select register.
  output logic             fetch_o,            // Pulse: an instruction word was taken on the last edge.
  output logic [11:0]      mem_addr_o,         // Data memory address.
  output logic             mem_rd_o,           // Data memory read strobe.
  output logic             mem_wr_o,           // Data memory write strobe.
  output logic [7:0]       mem_wdata_o,        // Data memory write data.
  output logic [7:0]       accumulator_o,      // Accumulator contents.
  output logic [7:0]       product_high_byte_o,
  output logic [7:0]       product_low_byte_o,
  output logic [4:0]       flags_o,            // N, OV, Z, DC, C from bit 4 down.
  output logic [3:0]       bank_select_register_o
);
  mnsx_pkg::mnsx_phase_t phase_reg;     // Current quarter of the instruction cycle.
  mnsx_pkg::mnsx_phase_t phase_next;
  mnsx_pkg::mnsx_op_t    op_reg;        // Operation held for the rest of the cycle.
  mnsx_pkg::mnsx_op_t    op_dec;        // Operation decoded from the incoming word.
  logic [15:0]           ir_reg;        // Instruction word held from decode onward.
  logic [7:0]            opnd_reg;      // File operand captured in the process phase.
  logic [7:0]            acc_reg;       // Accumulator.
  logic [7:0]            ph_reg;        // Product high byte.
  logic [7:0]            pl_reg;        // Product low byte.
  logic [4:0]            flg_reg;       // Status flags, N down to C.
  logic [4:0]            flg_new;       // Flags that a subtract or negate would produce.
  logic [3:0]            bank_reg;      // Bank select register.
  logic [11:0]           addr_reg;      // Registered data memory address.
  logic                  rd_reg;        // Data memory read strobe.
  logic                  wr_reg;        // Data memory write strobe.
  logic                  fetch_reg;     // Pulse after each instruction word is taken.
  logic [7:0]            wdata_reg;     // Registered data memory write data.

  // Decode of the incoming word; anything unknown behaves as idle.
  assign op_dec = (instr_i[15:8] == mnsx_pkg::OP_MUL_LIT)  ? mnsx_pkg::OPK_MUL_LIT  :
                  (instr_i[15:9] == mnsx_pkg::OP_MUL_FILE) ? mnsx_pkg::OPK_MUL_FILE :
                  (instr_i[15:9] == mnsx_pkg::OP_NEG_FILE) ? mnsx_pkg::OPK_NEG      :
                  (instr_i[15:10] == mnsx_pkg::OP_SUB_FILE) ? mnsx_pkg::OPK_SUB_FILE :
                  (instr_i[15:8] == mnsx_pkg::OP_SUB_LIT)  ? mnsx_pkg::OPK_SUB_LIT  :
                  mnsx_pkg::OPK_IDLE;

  // Operand address: access bank overrides the bank select when the access bit is 0.
  wire        uses_file = (op_reg == mnsx_pkg::OPK_MUL_FILE) || (op_reg == mnsx_pkg::OPK_NEG) ||
                          (op_reg == mnsx_pkg::OPK_SUB_FILE);
  wire [7:0]  f_off     = ir_reg[7:0];
  wire [3:0]  acc_bank  = (f_off < mnsx_pkg::ACCESS_SPLIT) ? mnsx_pkg::RST_BANK
                                                           : mnsx_pkg::ACCESS_HIGH_BANK;
  wire [11:0] f_addr    = ir_reg[mnsx_pkg::ACCESS_BIT] ? {bank_reg, f_off}
                                                       : {acc_bank, f_off};

  // Minuend and subtrahend for the arithmetic of the write phase.
  wire        is_neg  = (op_reg == mnsx_pkg::OPK_NEG);
  wire [7:0]  src_b   = (op_reg == mnsx_pkg::OPK_SUB_LIT) ? ir_reg[7:0] : opnd_reg;
  wire [7:0]  minuend = is_neg ? 8'h00 : src_b;
  wire [7:0]  subtra  = is_neg ? opnd_reg : acc_reg;
  // Both subtraction and negation are minuend + ~subtrahend + 1.
  wire [8:0]  diff    = {1'b0, minuend} + {1'b0, ~subtra} + 9'h001;
  wire [4:0]  ndiff   = {1'b0, minuend[3:0]} + {1'b0, ~subtra[3:0]} + 5'h01;
  wire        ov      = (minuend[7] != subtra[7]) && (diff[7] != minuend[7]);
  // Carry out of the add form is the inverted borrow, so no extra inversion is needed.
  always_comb begin
    flg_new                   = mnsx_pkg::RST_FLAGS;
    flg_new[mnsx_pkg::FLG_N]  = diff[7];
    flg_new[mnsx_pkg::FLG_OV] = ov;
    flg_new[mnsx_pkg::FLG_Z]  = (diff[7:0] == 8'h00);
    flg_new[mnsx_pkg::FLG_DC] = ndiff[4];
    flg_new[mnsx_pkg::FLG_C]  = diff[8];
  end
  wire [15:0] product = acc_reg * src_b;
  wire        to_acc  = (op_reg == mnsx_pkg::OPK_SUB_LIT) ||
                        ((op_reg == mnsx_pkg::OPK_SUB_FILE) && !ir_reg[mnsx_pkg::DEST_BIT]);
  wire        to_file = is_neg ||
                        ((op_reg == mnsx_pkg::OPK_SUB_FILE) && ir_reg[mnsx_pkg::DEST_BIT]);
  wire        sets_flg = is_neg || (op_reg == mnsx_pkg::OPK_SUB_FILE) ||
                         (op_reg == mnsx_pkg::OPK_SUB_LIT);

  // Phases run in fixed order, one instruction every four clocks.
  always_comb begin
    unique case (phase_reg)
      mnsx_pkg::PH_DECODE:  phase_next = mnsx_pkg::PH_READ;
      mnsx_pkg::PH_READ:    phase_next = mnsx_pkg::PH_PROCESS;
      mnsx_pkg::PH_PROCESS: phase_next = mnsx_pkg::PH_WRITE;
      mnsx_pkg::PH_WRITE:   phase_next = mnsx_pkg::PH_DECODE;
    endcase
  end

  // Phase strobes; each is high for exactly one clock of the four.
  wire        in_decode  = (phase_reg == mnsx_pkg::PH_DECODE);
  wire        in_read    = (phase_reg == mnsx_pkg::PH_READ);
  wire        in_process = (phase_reg == mnsx_pkg::PH_PROCESS);
  wire        in_write   = (phase_reg == mnsx_pkg::PH_WRITE);
  // Both multiply forms share the product path.
  wire        is_mul     = (op_reg == mnsx_pkg::OPK_MUL_LIT) ||
                           (op_reg == mnsx_pkg::OPK_MUL_FILE);

  // Phase counter: the only sequencing state, it never waits on anything outside.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_reg <= mnsx_pkg::PH_DECODE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // Decode: capture the word and its operation, and pulse the fetch strobe.
  // The word is held for the whole cycle so the later phases see a stable operand field.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ir_reg    <= 16'h0000;
      op_reg    <= mnsx_pkg::OPK_IDLE;
      fetch_reg <= 1'b0;
    end else begin
      fetch_reg <= in_decode;
      if (in_decode) begin
        ir_reg <= instr_i;
        op_reg <= op_dec;
      end
    end
  end

  // Bank select register; a load at any time is picked up by the next read phase.
  // A load in the same cycle as a read phase only affects the following instruction.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bank_reg <= mnsx_pkg::RST_BANK;
    end else if (bank_wr_i) begin
      bank_reg <= bank_wr_data_i;
    end
  end

  // Read phase: drive the address and the strobe.
  // Idle and literal forms leave the memory alone, so no stray read side effects occur.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      addr_reg <= 12'h000;
      rd_reg   <= 1'b0;
    end else begin
      rd_reg <= in_read && uses_file;
      if (in_read) begin
        addr_reg <= f_addr;
      end
    end
  end

  // Process phase: the operand is taken while the read strobe stands.
  // The address is held until the next read phase, so the write goes to the same place.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      opnd_reg <= mnsx_pkg::RST_BYTE;
    end else if (in_process) begin
      opnd_reg <= mem_rdata_i;
    end
  end

  // Write phase, accumulator: only the subtract forms aimed at it may load it.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_reg <= mnsx_pkg::RST_BYTE;
    end else if (in_write && to_acc) begin
      acc_reg <= diff[7:0];
    end
  end

  // Write phase, flags: only subtract and negate update them.
  // Multiply and idle words keep the old flags, so a zero product sets nothing.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flg_reg <= mnsx_pkg::RST_FLAGS;
    end else if (in_write && sets_flg) begin
      flg_reg <= flg_new;
    end
  end

  // Write phase, product pair: both bytes load together so software never sees a torn pair.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ph_reg <= mnsx_pkg::RST_BYTE;
      pl_reg <= mnsx_pkg::RST_BYTE;
    end else if (in_write && is_mul) begin
      ph_reg <= product[15:8];
      pl_reg <= product[7:0];
    end
  end

  // Write phase, memory: a one-clock strobe with the data beside it.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_reg    <= 1'b0;
      wdata_reg <= mnsx_pkg::RST_BYTE;
    end else begin
      wr_reg <= in_write && to_file;
      if (in_write && to_file) begin
        wdata_reg <= diff[7:0];
      end
    end
  end

  // Every output is a plain copy of a register.
  assign fetch_o                = fetch_reg;
  assign mem_addr_o             = addr_reg;
  assign mem_rd_o               = rd_reg;
  assign mem_wr_o               = wr_reg;
  assign mem_wdata_o            = wdata_reg;
  assign accumulator_o          = acc_reg;
  assign product_high_byte_o    = ph_reg;
  assign product_low_byte_o     = pl_reg;
  assign flags_o                = flg_reg;
  assign bank_select_register_o = bank_reg;
endmodule : mnsx_exec_unit
`default_nettype wire

/* test/mnsx_exec_unit_asserts.sv */
// Checker that watches the execution unit ports for timing and side effects.
`timescale 1ns/1ps
`default_nettype none
module mnsx_exec_unit_asserts (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        bank_wr_i,
  input wire logic [3:0]  bank_wr_data_i,
  input wire logic        fetch_o,
  input wire logic        mem_rd_o,
  input wire logic        mem_wr_o,
  input wire logic [11:0] mem_addr_o,
  input wire logic [7:0]  accumulator_o,
  input wire logic [7:0]  product_high_byte_o,
  input wire logic [4:0]  flags_o,
  input wire logic [3:0]  bank_select_register_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Results may only land at the end of the fourth phase, three clocks after the fetch pulse.
  property p_fetch; fetch_o |=> !fetch_o [*3] ##1 fetch_o; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch spacing wrong");
  property p_rd; mem_rd_o |-> $past(fetch_o); endproperty
  a_rd: assert property (p_rd) else $error("read strobe misplaced");
  property p_wr; mem_wr_o |-> $past(mem_rd_o, 2) && $past(fetch_o, 3); endproperty
  a_wr: assert property (p_wr) else $error("write without matching read");
  property p_addr; mem_rd_o |=> $stable(mem_addr_o) [*2]; endproperty
  a_addr: assert property (p_addr) else $error("address moved before write");
  property p_acc_wr; mem_wr_o |-> $stable(accumulator_o); endproperty
  a_acc_wr: assert property (p_acc_wr) else $error("memory write touched acc");
  property p_prod; $changed(product_high_byte_o) |-> $stable(flags_o); endproperty
  a_prod: assert property (p_prod) else $error("multiply changed flags");
  property p_flg; $changed(flags_o) |-> $past(fetch_o, 3); endproperty
  a_flg: assert property (p_flg) else $error("flags changed off phase");
  property p_acc; $changed(accumulator_o) |-> $past(fetch_o, 3); endproperty
  a_acc: assert property (p_acc) else $error("acc changed off phase");
  property p_bank; bank_wr_i |=> bank_select_register_o == $past(bank_wr_data_i); endproperty
  a_bank: assert property (p_bank) else $error("bank load lost");
  // Main scenarios: a memory write, a product change and an accumulator change.
  c_wr: cover property (mem_wr_o);
  c_prod: cover property ($changed(product_high_byte_o));
  c_acc: cover property ($changed(accumulator_o));
endmodule : mnsx_exec_unit_asserts
`default_nettype wire

/* test/mnsx_exec_unit_tb.sv */
// Self-checking bench for the multiply, negate and subtract execution unit.
`timescale 1ns/1ps
`default_nettype none
module mnsx_exec_unit_tb;
  logic        clk_i = 1'b0, resetn_i = 1'b0, bank_wr_i = 1'b0, fetch, rd, wr;
  logic [15:0] instr_i = 16'h0000;
  logic [7:0]  mem_rdata_i = 8'h00, acc, ph, pl, wd;
  logic [3:0]  bank_wr_data_i = 4'h0, bank_select_register;
  logic [11:0] addr;
  logic [4:0]  flg;
  int          fails = 0, num_checks = 0;
  mnsx_exec_unit mnsx_exec_unit_i (.clk_i, .resetn_i, .instr_i, .mem_rdata_i, .bank_wr_data_i,
    .bank_wr_i, .fetch_o(fetch), .mem_addr_o(addr), .mem_rd_o(rd), .mem_wr_o(wr),
    .mem_wdata_o(wd), .accumulator_o(acc), .product_high_byte_o(ph),
    .product_low_byte_o(pl), .flags_o(flg), .bank_select_register_o(bank_select_register));
  // Clock at 100 MHz.
  initial forever #5 clk_i = ~clk_i;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // Waits for a fetch pulse, drives the word for the next take edge, checks while wr stands.
  task automatic step(input logic [15:0] ins, input logic [7:0] rdat, input logic [7:0] eacc,
                      input logic [4:0] eflg, input logic ewr);
    int n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (fetch !== 1'b1 && n < 9);
    if (fetch !== 1'b1) begin
      fails++;
      end_sim();
    end
    repeat (3) @(posedge clk_i);
    instr_i <= ins;
    mem_rdata_i <= rdat;
    @(posedge clk_i);
    instr_i <= 16'h0000;
    repeat (3) @(posedge clk_i);
    #1;
    chk(16'(acc), 16'(eacc));
    chk(16'(flg), 16'(eflg));
    chk(16'(wr), 16'(ewr));
  endtask : step
  task automatic t_sub_lit();
    step(16'h0803, 8'h00, 8'h03, 5'b00011, 1'b0);
    step(16'h0802, 8'h00, 8'hFF, 5'b10000, 1'b0);
    $display("literal subtract test done");
  endtask : t_sub_lit
  task automatic t_mul();
    step(16'h0210, 8'hB5, 8'hFF, 5'b10000, 1'b0);
    chk({ph, pl}, 16'hB44B);
    chk(16'(addr), 16'h0010);
    step(16'h0D00, 8'h00, 8'hFF, 5'b10000, 1'b0);
    chk({ph, pl}, 16'h0000);
    $display("multiply test done");
  endtask : t_mul
  task automatic t_neg();
    @(posedge clk_i);
    bank_wr_i <= 1'b1;
    bank_wr_data_i <= 4'h3;
    @(posedge clk_i);
    bank_wr_i <= 1'b0;
    step(16'h6D3A, 8'h80, 8'hFF, 5'b11010, 1'b1);
    chk({wd, bank_select_register, addr[11:8]}, 16'h8033);
    chk(16'(addr), 16'h033A);
    step(16'h6C90, 8'h00, 8'hFF, 5'b00111, 1'b1);
    chk({wd, addr[11:4]}, 16'h00F9);
    $display("negate test done");
  endtask : t_neg
  task automatic t_sub_file();
    step(16'h5D05, 8'h01, 8'h02, 5'b00000, 1'b0);
    step(16'h5F05, 8'h03, 8'h02, 5'b00011, 1'b1);
    chk({wd, 8'h00}, 16'h0100);
    step(16'h0000, 8'h55, 8'h02, 5'b00011, 1'b0);
    step(16'hF123, 8'h55, 8'h02, 5'b00011, 1'b0);
    $display("file subtract and idle test done");
  endtask : t_sub_file
  // Reset for 20 cycles, then run every scenario in turn.
  initial begin
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_sub_lit();
    t_mul();
    t_neg();
    t_sub_file();
    end_sim();
  end
endmodule : mnsx_exec_unit_tb
bind mnsx_exec_unit mnsx_exec_unit_asserts mnsx_exec_unit_asserts_i (
  .clk_i                  (clk_i),
  .resetn_i               (resetn_i),
  .bank_wr_i              (bank_wr_i),
  .bank_wr_data_i         (bank_wr_data_i),
  .fetch_o                (fetch_o),
  .mem_rd_o               (mem_rd_o),
  .mem_wr_o               (mem_wr_o),
  .mem_addr_o             (mem_addr_o),
  .accumulator_o          (accumulator_o),
  .product_high_byte_o    (product_high_byte_o),
  .flags_o                (flags_o),
  .bank_select_register_o (bank_select_register_o)
);
`default_nettype wire
